/* hdl/ctb_pkg.sv */
// Purpose: shared constants and types for the transmit buffer scheduler
// Assumes: three transmit buffers, 250 MHz system clock, 6 ns link clock
// Notes: message bytes per buffer exclude the control byte, which lives in flops
package ctb_pkg;
  localparam int NBUF = 3;
  localparam int BUF_BYTES = 14;
  localparam int ID_BYTES = 5;
  localparam int DATA_BYTES = 8;
  localparam int MSG_BYTES = ID_BYTES + DATA_BYTES;
  localparam int BUF_AW = 2;
  localparam int SLOT_AW = 4;
  localparam int MEM_AW = BUF_AW + SLOT_AW;
  localparam int MEM_DEPTH = NBUF << SLOT_AW;
  localparam logic [BUF_AW-1:0] BUF_LAST = BUF_AW'(NBUF - 1);
  localparam logic [SLOT_AW-1:0] MSG_LAST = SLOT_AW'(MSG_BYTES - 1);
  localparam logic [1:0] PRIO_HIGHEST = 2'h3;
  localparam logic [1:0] PRIO_LOWEST = 2'h0;
  localparam logic [1:0] IFS_BITS = 2'h3;
  localparam logic [1:0] IFS_LAST = IFS_BITS - 2'h1;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int LINK_PERIOD_PS = 6000;
  localparam int SYNC_LAG_PS = 3 * LINK_PERIOD_PS;
  localparam int GUARD_CYC = (SYNC_LAG_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
  localparam logic [2:0] GUARD_LOAD = 3'(GUARD_CYC);
  typedef enum logic [1:0] {
    RES_OK = 2'h0,
    RES_ARB = 2'h1,
    RES_ERR = 2'h2
  } ctb_result_t;
  typedef enum logic [1:0] {
    LS_IFS = 2'h0,
    LS_IDLE = 2'h1,
    LS_OURS = 2'h2,
    LS_BUSY = 2'h3
  } ctb_link_state_t;
endpackage

/* hdl/ctb_sync.sv */
// Purpose: two-flop synchroniser with a third flop for edge detection
// Assumes: din comes from another clock domain or a pin
// Notes: stage one feeds only stage two
`timescale 1ns/1ps
module ctb_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] level,
  output logic [W-1:0] fall,
  output logic [W-1:0] change
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } ctb_sync_st_t;
  ctb_sync_st_t q_r;
  ctb_sync_st_t q_nxt;
  always_comb begin
    q_nxt = q_r;
    q_nxt.s1 = din;
    q_nxt.s2 = q_r.s1;
    q_nxt.s3 = q_r.s2;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= {INIT, INIT, INIT};
    end else begin
      q_r <= q_nxt;
    end
  end
  assign level = q_r.s2;
  assign fall = q_r.s3 & ~q_r.s2;
  assign change = q_r.s3 ^ q_r.s2;
endmodule

/* hdl/ctb_msg_mem.sv */
// Purpose: message byte store, written by the host, read on the link clock
// Assumes: the host leaves a pending buffer untouched while it is read
// Notes: read data come out of a register on the read clock
`timescale 1ns/1ps
module ctb_msg_mem #(
  parameter int AW = ctb_pkg::MEM_AW,
  parameter int DEPTH = ctb_pkg::MEM_DEPTH
) (
  input wire logic wclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic rclk,
  input wire logic rrst_n,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [DEPTH];
  always_ff @(posedge wclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
  always_ff @(posedge rclk or negedge rrst_n) begin
    if (!rrst_n) begin
      rdata <= 8'h00;
    end else if (int'(raddr) < DEPTH) begin
      rdata <= mem[raddr];
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule

/* hdl/ctb_tx_sched.sv */
// Purpose: transmit buffer control, priority choice and frame start timing
// Assumes: a protocol engine on link_clk sends frames and reports outcomes
// Notes: host side runs on clk; link side on link_clk; toggles cross events
`timescale 1ns/1ps
module ctb_tx_sched (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic [ctb_pkg::NBUF-1:0] ctrl_wr,
  input wire logic ctrl_wr_req,
  input wire logic [1:0] ctrl_wr_prio,
  input wire logic [ctb_pkg::NBUF-1:0] rts_cmd,
  input wire logic abort_all_request,
  input wire logic single_attempt_mode,
  input wire logic config_mode,
  input wire logic pin_ctrl_wr,
  input wire logic [ctb_pkg::NBUF-1:0] pin_ctrl_mode,
  input wire logic [ctb_pkg::NBUF-1:0] tx_done_irq_enable,
  input wire logic message_fault_enable,
  input wire logic [ctb_pkg::NBUF-1:0] done_flag_clr,
  input wire logic fault_flag_clr,
  input wire logic mem_wr,
  input wire logic [ctb_pkg::BUF_AW-1:0] mem_wbuf,
  input wire logic [ctb_pkg::SLOT_AW-1:0] mem_wbyte,
  input wire logic [7:0] mem_wdata,
  input wire logic [ctb_pkg::NBUF-1:0] tx_request_pin_n,
  output logic [ctb_pkg::NBUF-1:0] tx_request_bit,
  output logic [2*ctb_pkg::NBUF-1:0] tx_priority_field,
  output logic [ctb_pkg::NBUF-1:0] aborted_flag,
  output logic [ctb_pkg::NBUF-1:0] lost_arbitration_flag,
  output logic [ctb_pkg::NBUF-1:0] tx_fault_flag,
  output logic [ctb_pkg::NBUF-1:0] tx_done_flag,
  output logic message_fault_flag,
  output logic irq_n,
  output logic [ctb_pkg::NBUF-1:0] pin_state,
  output logic [ctb_pkg::NBUF-1:0] request_pin_mode,
  input wire logic bit_tick,
  input wire logic bus_rx,
  input wire logic eng_frame_end,
  input wire logic eng_tx_ok,
  input wire logic eng_arb_lost,
  input wire logic eng_tx_err,
  input wire logic [ctb_pkg::SLOT_AW-1:0] eng_byte_addr,
  output logic tx_start,
  output logic [ctb_pkg::BUF_AW-1:0] tx_buf_sel,
  output logic bus_avail,
  output logic [7:0] eng_rdata
);
  localparam int N = ctb_pkg::NBUF;
  localparam int BW = ctb_pkg::BUF_AW;

  typedef struct packed {
    logic [N-1:0] req;
    logic [N-1:0][1:0] prio;
    logic [N-1:0] aborted;
    logic [N-1:0] lost;
    logic [N-1:0] fault;
    logic [N-1:0] done;
    logic merr;
    logic irq_n;
    logic [N-1:0] pin_mode;
    logic [N-1:0] pin_state;
    logic offer;
    logic [BW-1:0] sel;
    logic [2:0] guard;
    logic inflight;
    logic [BW-1:0] inflight_id;
    logic abort_hit;
  } ctb_host_st_t;

  typedef struct packed {
    ctb_pkg::ctb_link_state_t state;
    logic [1:0] ifs_cnt;
    logic start;
    logic avail;
    logic [BW-1:0] sel;
    logic st_tgl;
    logic res_tgl;
    ctb_pkg::ctb_result_t res_code;
  } ctb_link_st_t;

  ctb_host_st_t h_r;
  ctb_host_st_t h_nxt;
  ctb_link_st_t l_r;
  ctb_link_st_t l_nxt;

  logic link_rst1_r;
  logic link_rst_n;
  logic [N-1:0] pin_lvl;
  logic [N-1:0] pin_fall;
  logic st_evt;
  logic rs_evt;
  logic offer_seen;
  logic best_v;
  logic [BW-1:0] best;
  logic [1:0] best_p;
  logic mem_we;

  // link-side reset: asserted at once, released on link_clk
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_rst1_r <= 1'b0;
      link_rst_n <= 1'b0;
    end else begin
      link_rst1_r <= 1'b1;
      link_rst_n <= link_rst1_r;
    end
  end

  // request pins idle high through their pull-ups
  ctb_sync #(.W(N), .INIT('1)) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din(tx_request_pin_n),
    .level(pin_lvl),
    .fall(pin_fall),
    .change()
  );

  ctb_sync #(.W(1), .INIT(1'b0)) u_start_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din(l_r.st_tgl),
    .level(),
    .fall(),
    .change(st_evt)
  );

  ctb_sync #(.W(1), .INIT(1'b0)) u_result_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din(l_r.res_tgl),
    .level(),
    .fall(),
    .change(rs_evt)
  );

  ctb_sync #(.W(1), .INIT(1'b0)) u_offer_sync (
    .clk(link_clk),
    .rst_n(link_rst_n),
    .din(h_r.offer),
    .level(offer_seen),
    .fall(),
    .change()
  );

  // message bytes; a pending buffer refuses writes
  assign mem_we = mem_wr && !h_r.req[mem_wbuf] && (mem_wbuf <= ctb_pkg::BUF_LAST)
    && (mem_wbyte <= ctb_pkg::MSG_LAST);

  ctb_msg_mem #(.AW(ctb_pkg::MEM_AW), .DEPTH(ctb_pkg::MEM_DEPTH)) u_mem (
    .wclk(clk),
    .we(mem_we),
    .waddr({mem_wbuf, mem_wbyte}),
    .wdata(mem_wdata),
    .rclk(link_clk),
    .rrst_n(link_rst_n),
    .raddr({l_r.sel, eng_byte_addr}),
    .rdata(eng_rdata)
  );

  // choose among pending buffers; ties go to the higher number
  always_comb begin
    best_v = 1'b0;
    best = '0;
    best_p = ctb_pkg::PRIO_LOWEST;
    for (int i = 0; i < N; i++) begin
      if (h_r.req[i] && (!best_v || h_r.prio[i] >= best_p)) begin
        best_v = 1'b1;
        best = BW'(i);
        best_p = h_r.prio[i];
      end
    end
    if (abort_all_request || h_r.inflight) begin
      best_v = 1'b0;
    end
  end

  always_comb begin
    logic set_i;
    logic own_i;
    logic fail_i;
    set_i = 1'b0;
    own_i = 1'b0;
    fail_i = 1'b0;
    h_nxt = h_r;
    if (pin_ctrl_wr && config_mode) begin
      h_nxt.pin_mode = pin_ctrl_mode;
    end
    h_nxt.pin_state = pin_lvl;
    if (fault_flag_clr) begin
      h_nxt.merr = 1'b0;
    end
    for (int i = 0; i < N; i++) begin
      set_i = (ctrl_wr[i] && ctrl_wr_req) || rts_cmd[i]
        || (h_r.pin_mode[i] && pin_fall[i]);
      own_i = h_r.inflight && (h_r.inflight_id == BW'(i));
      if (ctrl_wr[i]) begin
        h_nxt.prio[i] = ctrl_wr_prio;
        h_nxt.req[i] = ctrl_wr_req;
      end
      if (set_i) begin
        h_nxt.req[i] = 1'b1;
        h_nxt.aborted[i] = 1'b0;
        h_nxt.lost[i] = 1'b0;
        h_nxt.fault[i] = 1'b0;
      end
      if (abort_all_request && h_nxt.req[i]) begin
        if (own_i) begin
          h_nxt.abort_hit = 1'b1;
        end else begin
          h_nxt.req[i] = 1'b0;
          h_nxt.aborted[i] = 1'b1;
        end
      end
      if (done_flag_clr[i]) begin
        h_nxt.done[i] = 1'b0;
      end
      if (rs_evt && own_i) begin
        fail_i = 1'b1;
        unique case (l_r.res_code)
          ctb_pkg::RES_OK: begin
            h_nxt.req[i] = 1'b0;
            h_nxt.done[i] = 1'b1;
            fail_i = 1'b0;
          end
          ctb_pkg::RES_ARB: begin
            h_nxt.lost[i] = 1'b1;
          end
          ctb_pkg::RES_ERR: begin
            h_nxt.fault[i] = 1'b1;
            h_nxt.merr = 1'b1;
          end
          default: begin
            fail_i = 1'b0;
          end
        endcase
        if (fail_i && (single_attempt_mode || h_r.abort_hit || abort_all_request)) begin
          h_nxt.req[i] = 1'b0;
          h_nxt.aborted[i] = 1'b1;
        end
      end
    end
    if (rs_evt) begin
      h_nxt.inflight = 1'b0;
      h_nxt.abort_hit = 1'b0;
    end
    // offer handshake: sel only moves while the offer is down and the guard ran out
    if (h_r.guard != 3'h0) begin
      h_nxt.guard = h_r.guard - 3'h1;
    end
    if (st_evt) begin
      h_nxt.inflight = 1'b1;
      h_nxt.inflight_id = l_r.sel;
      h_nxt.offer = 1'b0;
      h_nxt.guard = ctb_pkg::GUARD_LOAD;
    end else if (h_r.offer && (!best_v || best != h_r.sel)) begin
      h_nxt.offer = 1'b0;
      h_nxt.guard = ctb_pkg::GUARD_LOAD;
    end else if (!h_r.offer && h_r.guard == 3'h0 && best_v) begin
      h_nxt.offer = 1'b1;
      h_nxt.sel = best;
    end
    h_nxt.irq_n = !(|(h_nxt.done & tx_done_irq_enable)
      || (h_nxt.merr && message_fault_enable));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      h_r <= '{
        req: '0,
        prio: '0,
        aborted: '0,
        lost: '0,
        fault: '0,
        done: '0,
        merr: 1'b0,
        irq_n: 1'b1,
        pin_mode: '0,
        pin_state: '1,
        offer: 1'b0,
        sel: '0,
        guard: 3'h0,
        inflight: 1'b0,
        inflight_id: '0,
        abort_hit: 1'b0
      };
    end else begin
      h_r <= h_nxt;
    end
  end

  // link side: intermission count, frame start, outcome return
  always_comb begin
    l_nxt = l_r;
    l_nxt.start = 1'b0;
    unique case (l_r.state)
      ctb_pkg::LS_IFS: begin
        if (bit_tick) begin
          if (bus_rx) begin
            if (l_r.ifs_cnt == ctb_pkg::IFS_LAST) begin
              l_nxt.state = ctb_pkg::LS_IDLE;
              l_nxt.avail = 1'b1;
            end else begin
              l_nxt.ifs_cnt = l_r.ifs_cnt + 2'h1;
            end
          end else if (l_r.ifs_cnt == ctb_pkg::IFS_LAST) begin
            l_nxt.state = ctb_pkg::LS_BUSY;
          end else begin
            l_nxt.ifs_cnt = 2'h0;
          end
        end
      end
      ctb_pkg::LS_IDLE: begin
        if (bit_tick && !bus_rx) begin
          l_nxt.state = ctb_pkg::LS_BUSY;
          l_nxt.avail = 1'b0;
        end else if (offer_seen) begin
          l_nxt.state = ctb_pkg::LS_OURS;
          l_nxt.avail = 1'b0;
          l_nxt.start = 1'b1;
          l_nxt.sel = h_r.sel;
          l_nxt.st_tgl = !l_r.st_tgl;
        end
      end
      ctb_pkg::LS_OURS: begin
        if (eng_tx_ok) begin
          l_nxt.res_code = ctb_pkg::RES_OK;
          l_nxt.res_tgl = !l_r.res_tgl;
        end else if (eng_tx_err) begin
          l_nxt.res_code = ctb_pkg::RES_ERR;
          l_nxt.res_tgl = !l_r.res_tgl;
        end else if (eng_arb_lost) begin
          l_nxt.res_code = ctb_pkg::RES_ARB;
          l_nxt.res_tgl = !l_r.res_tgl;
        end
        if (eng_frame_end) begin
          l_nxt.state = ctb_pkg::LS_IFS;
          l_nxt.ifs_cnt = 2'h0;
        end
      end
      ctb_pkg::LS_BUSY: begin
        if (eng_frame_end) begin
          l_nxt.state = ctb_pkg::LS_IFS;
          l_nxt.ifs_cnt = 2'h0;
        end
      end
    endcase
  end

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      l_r <= '{
        state: ctb_pkg::LS_IFS,
        ifs_cnt: 2'h0,
        start: 1'b0,
        avail: 1'b0,
        sel: '0,
        st_tgl: 1'b0,
        res_tgl: 1'b0,
        res_code: ctb_pkg::RES_OK
      };
    end else begin
      l_r <= l_nxt;
    end
  end

  assign tx_request_bit = h_r.req;
  assign tx_priority_field = h_r.prio;
  assign aborted_flag = h_r.aborted;
  assign lost_arbitration_flag = h_r.lost;
  assign tx_fault_flag = h_r.fault;
  assign tx_done_flag = h_r.done;
  assign message_fault_flag = h_r.merr;
  assign irq_n = h_r.irq_n;
  assign pin_state = h_r.pin_state;
  assign request_pin_mode = h_r.pin_mode;
  assign tx_start = l_r.start;
  assign tx_buf_sel = l_r.sel;
  assign bus_avail = l_r.avail;
endmodule

/* dv/ctb_tx_sched_asserts.sv */
// Purpose: concurrent checks on the transmit buffer scheduler ports
// Assumes: host group on clk, link group on link_clk, async active-low reset
// Notes: bound into every ctb_tx_sched instance
`timescale 1ns/1ps
module ctb_tx_sched_chk (
  input logic clk,
  input logic link_clk,
  input logic rst_n,
  input logic [2:0] ctrl_wr,
  input logic ctrl_wr_req,
  input logic [1:0] ctrl_wr_prio,
  input logic abort_all_request,
  input logic single_attempt_mode,
  input logic config_mode,
  input logic pin_ctrl_wr,
  input logic [2:0] tx_done_irq_enable,
  input logic message_fault_enable,
  input logic [2:0] tx_request_bit,
  input logic [5:0] tx_priority_field,
  input logic [2:0] aborted_flag,
  input logic [2:0] lost_arbitration_flag,
  input logic [2:0] tx_fault_flag,
  input logic [2:0] tx_done_flag,
  input logic message_fault_flag,
  input logic irq_n,
  input logic [2:0] pin_state,
  input logic [2:0] request_pin_mode,
  input logic tx_start,
  input logic bus_avail
);
  property p_req_set;
    @(posedge clk) disable iff (!rst_n) ctrl_wr[0] && ctrl_wr_req && !abort_all_request |=>
      tx_request_bit[0] && !(aborted_flag[0] || lost_arbitration_flag[0] || tx_fault_flag[0]);
  endproperty
  a_req_set: assert property (p_req_set) else $error("request write did not set and clear");
  property p_prio;
    @(posedge clk) disable iff (!rst_n) ctrl_wr[1] |=> tx_priority_field[3:2] == $past(ctrl_wr_prio);
  endproperty
  a_prio: assert property (p_prio) else $error("priority not taken with write");
  property p_host_abort;
    @(posedge clk) disable iff (!rst_n)
      ctrl_wr[2] && !ctrl_wr_req && !single_attempt_mode && !abort_all_request |=>
      !tx_request_bit[2] && aborted_flag[2] == $past(aborted_flag[2]);
  endproperty
  a_host_abort: assert property (p_host_abort) else $error("host abort misbehaved");
  property p_done_clears;
    @(posedge clk) disable iff (!rst_n) $rose(tx_done_flag[0]) |-> !tx_request_bit[0];
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("done with request still set");
  property p_err_keeps;
    @(posedge clk) disable iff (!rst_n) $rose(tx_fault_flag[0]) && !single_attempt_mode &&
      !abort_all_request && $past(tx_request_bit[0]) |-> tx_request_bit[0] && message_fault_flag;
  endproperty
  a_err_keeps: assert property (p_err_keeps) else $error("error dropped request");
  property p_single;
    @(posedge clk) disable iff (!rst_n) $rose(lost_arbitration_flag[1]) && single_attempt_mode |->
      !tx_request_bit[1] && aborted_flag[1];
  endproperty
  a_single: assert property (p_single) else $error("single attempt kept request");
  property p_abort_clears;
    @(posedge clk) disable iff (!rst_n) $rose(aborted_flag[1]) |-> !tx_request_bit[1];
  endproperty
  a_abort_clears: assert property (p_abort_clears) else $error("aborted but pending");
  property p_irq;
    @(posedge clk) disable iff (!rst_n) $stable(tx_done_irq_enable) && $stable(message_fault_enable)
      |-> irq_n == !(|(tx_done_flag & tx_done_irq_enable) || (message_fault_flag && message_fault_enable));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt line wrong");
  property p_cfg;
    @(posedge clk) disable iff (!rst_n) pin_ctrl_wr && !config_mode |=> $stable(request_pin_mode);
  endproperty
  a_cfg: assert property (p_cfg) else $error("pin mode changed outside config");
  property p_pin;
    @(posedge clk) disable iff (!rst_n) request_pin_mode[0] && $fell(pin_state[0]) &&
      !abort_all_request |-> ##[0:3] tx_request_bit[0];
  endproperty
  a_pin: assert property (p_pin) else $error("pin fall did not request");
  property p_start;
    @(posedge link_clk) disable iff (!rst_n) tx_start |-> $past(bus_avail) && !bus_avail;
  endproperty
  a_start: assert property (p_start) else $error("start without free bus");
endmodule
bind ctb_tx_sched ctb_tx_sched_chk chk_u (.*);

/* dv/ctb_eng_model.sv */
// Purpose: protocol engine stand-in on the link clock
// Assumes: bus always recessive, frames of six bit times
// Notes: pause stops bit ticks only while idle; mode picks the outcome
`timescale 1ns/1ps
module ctb_eng_model (
  input logic link_clk,
  input logic rst_n,
  input logic tx_start,
  input logic pause,
  input logic [1:0] mode,
  output logic bit_tick,
  output logic bus_rx,
  output logic eng_frame_end,
  output logic eng_tx_ok,
  output logic eng_arb_lost,
  output logic eng_tx_err,
  output logic [3:0] eng_byte_addr,
  output logic [7:0] nstart
);
  logic busy_r;
  logic [2:0] cnt_r;
  assign bus_rx = 1'h1;
  assign eng_byte_addr = 4'h5;
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      {bit_tick, busy_r, eng_frame_end, eng_tx_ok, eng_arb_lost, eng_tx_err} <= 6'h00;
      cnt_r <= 3'h0;
      nstart <= 8'h00;
    end else begin
      bit_tick <= !bit_tick && (busy_r || tx_start || !pause);
      {eng_frame_end, eng_tx_ok, eng_arb_lost, eng_tx_err} <= 4'h0;
      if (tx_start) begin
        busy_r <= 1'h1;
        cnt_r <= 3'h0;
        nstart <= nstart + 8'h01;
      end else if (busy_r && bit_tick) begin
        cnt_r <= cnt_r + 3'h1;
        eng_tx_ok <= cnt_r == 3'h3 && mode == 2'h0;
        eng_arb_lost <= cnt_r == 3'h3 && mode == 2'h1;
        eng_tx_err <= cnt_r == 3'h3 && mode == 2'h2;
        if (cnt_r == 3'h5) begin
          eng_frame_end <= 1'h1;
          busy_r <= 1'h0;
        end
      end
    end
  end
endmodule

/* dv/ctb_tx_sched_tb.sv */
// Purpose: self-checking bench for the transmit buffer scheduler
// Assumes: host inputs change on the falling clk edge
// Notes: pause keeps the link idle so requests queue before arbitration
`timescale 1ns/1ps
module ctb_tx_sched_tb;
  logic clk = 1'h0;
  logic link_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [2:0] ctrl_wr = 3'h0, rts_cmd = 3'h0, pin_ctrl_mode = 3'h0, done_flag_clr = 3'h0;
  logic [2:0] tx_done_irq_enable = 3'h7, tx_request_pin_n = 3'h7;
  logic ctrl_wr_req = 1'h0, abort_all_request = 1'h0, single_attempt_mode = 1'h0;
  logic config_mode = 1'h0, pin_ctrl_wr = 1'h0, message_fault_enable = 1'h1;
  logic fault_flag_clr = 1'h0, mem_wr = 1'h0, pause = 1'h1;
  logic [1:0] ctrl_wr_prio = 2'h0, mem_wbuf = 2'h0, mode = 2'h0, tx_buf_sel;
  logic [3:0] mem_wbyte = 4'h5, eng_byte_addr;
  logic [7:0] mem_wdata = 8'h00, eng_rdata, nstart;
  logic [2:0] tx_request_bit, aborted_flag, lost_arbitration_flag, tx_fault_flag, tx_done_flag;
  logic [2:0] pin_state, request_pin_mode;
  logic [5:0] tx_priority_field;
  logic message_fault_flag, irq_n, bit_tick, bus_rx, eng_frame_end, eng_tx_ok, eng_arb_lost;
  logic eng_tx_err, tx_start, bus_avail;
  int err_total = 0, samples_checked = 0, cycles = 0;
  ctb_tx_sched dut_u (.*);
  ctb_eng_model eng_u (.*);
  always #2 clk = ~clk;
  initial begin
    #0.7;
    forever #3 link_clk = ~link_clk;
  end
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [1:0] b, logic rq, logic [1:0] p);
    ctrl_wr = 3'h1 << b;
    ctrl_wr_req = rq;
    ctrl_wr_prio = p;
    @(negedge clk);
    ctrl_wr = 3'h0;
    @(negedge clk);
  endtask
  task automatic mw(logic [3:0] a, logic [7:0] d);
    mem_wbyte = a;
    mem_wdata = d;
    mem_wr = 1'h1;
    @(negedge clk);
    mem_wr = 1'h0;
    @(negedge clk);
  endtask
  task automatic wstart(logic [1:0] exp);
    logic [7:0] n0;
    n0 = nstart;
    for (int i = 0; i < 400 && nstart == n0; i++) @(negedge clk);
    chk("starts", nstart - n0, 8'h01);
    chk("tx_buf_sel", 8'(tx_buf_sel), 8'(exp));
  endtask
  task automatic s_prio();
    mw(4'h0, 8'h12);
    mw(4'h1, 8'h34);
    mw(4'h4, 8'h01);
    mw(4'h5, 8'hA5);
    wr(2'h0, 1'h1, 2'h1);
    wr(2'h1, 1'h1, 2'h3);
    wr(2'h2, 1'h0, 2'h3);
    rts_cmd = 3'h4;
    @(negedge clk);
    rts_cmd = 3'h0;
    mw(4'h5, 8'h5A);
    chk("prio", 8'(tx_priority_field), 8'h3D);
    chk("req", 8'(tx_request_bit), 8'h07);
    pause = 1'h0;
    wstart(2'h2);
    wstart(2'h1);
    wstart(2'h0);
    repeat (4) @(negedge clk);
    chk("rdata", eng_rdata, 8'hA5);
    for (int i = 0; i < 400 && tx_done_flag != 3'h7; i++) @(negedge clk);
    chk("done", 8'({tx_done_flag, tx_request_bit, irq_n}), 8'h70);
    done_flag_clr = 3'h7;
    @(negedge clk);
    done_flag_clr = 3'h0;
    @(negedge clk);
    chk("irq_n", 8'(irq_n), 8'h01);
  endtask
  task automatic s_fail();
    mode = 2'h1;
    wr(2'h0, 1'h1, 2'h0);
    for (int i = 0; i < 400 && !lost_arbitration_flag[0]; i++) @(negedge clk);
    pause = 1'h1;
    chk("lost", 8'({tx_request_bit[0], lost_arbitration_flag[0]}), 8'h03);
    mode = 2'h2;
    pause = 1'h0;
    for (int i = 0; i < 400 && !tx_fault_flag[0]; i++) @(negedge clk);
    pause = 1'h1;
    chk("fault", 8'({tx_request_bit[0], tx_fault_flag[0], message_fault_flag, irq_n}), 8'h0E);
    repeat (40) @(negedge clk);
    wr(2'h0, 1'h0, 2'h0);
    fault_flag_clr = 1'h1;
    @(negedge clk);
    fault_flag_clr = 1'h0;
    @(negedge clk);
    chk("abort", 8'({tx_request_bit[0], aborted_flag[0], message_fault_flag}), 8'h00);
    mode = 2'h0;
    wr(2'h0, 1'h1, 2'h0);
    chk("flags", 8'({lost_arbitration_flag[0], tx_fault_flag[0]}), 8'h00);
    pause = 1'h0;
    for (int i = 0; i < 400 && tx_request_bit[0]; i++) @(negedge clk);
  endtask
  task automatic s_single();
    single_attempt_mode = 1'h1;
    mode = 2'h1;
    wr(2'h1, 1'h1, 2'h2);
    for (int i = 0; i < 400 && !aborted_flag[1]; i++) @(negedge clk);
    @(negedge clk);
    chk("single", 8'({tx_request_bit[1], lost_arbitration_flag[1], aborted_flag[1]}), 8'h03);
    pause = 1'h1;
    mode = 2'h0;
    single_attempt_mode = 1'h0;
  endtask
  task automatic s_abort();
    rts_cmd = 3'h2;
    @(negedge clk);
    rts_cmd = 3'h0;
    @(negedge clk);
    chk("rts", 8'({tx_request_bit[1], aborted_flag[1]}), 8'h02);
    abort_all_request = 1'h1;
    repeat (2) @(negedge clk);
    chk("abort_all_request", 8'({tx_request_bit[1], aborted_flag[1]}), 8'h01);
    abort_all_request = 1'h0;
    wr(2'h1, 1'h1, 2'h2);
    pause = 1'h0;
    for (int i = 0; i < 400 && tx_request_bit[1]; i++) @(negedge clk);
    pause = 1'h1;
    chk("resend", 8'({tx_request_bit[1], tx_done_flag[1]}), 8'h01);
  endtask
  task automatic s_flight();
    mode = 2'h1;
    wr(2'h1, 1'h1, 2'h2);
    pause = 1'h0;
    wstart(2'h1);
    pause = 1'h1;
    repeat (4) @(negedge clk);
    abort_all_request = 1'h1;
    repeat (2) @(negedge clk);
    chk("flight", 8'(tx_request_bit[1]), 8'h01);
    for (int i = 0; i < 400 && !aborted_flag[1]; i++) @(negedge clk);
    chk("fail", 8'({tx_request_bit[1], lost_arbitration_flag[1], aborted_flag[1]}), 8'h03);
    abort_all_request = 1'h0;
    mode = 2'h0;
  endtask
  task automatic s_pin();
    pin_ctrl_mode = 3'h1;
    pin_ctrl_wr = 1'h1;
    @(negedge clk);
    pin_ctrl_wr = 1'h0;
    @(negedge clk);
    chk("pmode", 8'(request_pin_mode), 8'h00);
    tx_request_pin_n = 3'h6;
    repeat (8) @(negedge clk);
    chk("plain", 8'({tx_request_bit[0], pin_state[0]}), 8'h00);
    tx_request_pin_n = 3'h7;
    config_mode = 1'h1;
    pin_ctrl_wr = 1'h1;
    @(negedge clk);
    pin_ctrl_wr = 1'h0;
    config_mode = 1'h0;
    repeat (8) @(negedge clk);
    chk("pmode", 8'(request_pin_mode), 8'h01);
    tx_request_pin_n = 3'h6;
    repeat (8) @(negedge clk);
    chk("pin", 8'(tx_request_bit[0]), 8'h01);
    tx_request_pin_n = 3'h7;
    wr(2'h0, 1'h0, 2'h0);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'h1;
    @(negedge clk);
    chk("reset", 8'({tx_request_bit, irq_n, pin_state, bus_avail}), 8'h1E);
    s_prio();
    s_fail();
    s_single();
    s_abort();
    s_flight();
    s_pin();
    test_done();
  end
endmodule
